// >>> tbxr_pkg.sv
// Purpose: Shared constants and carriers for the trigger bus crossbar router
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Register offsets are fixed here and used by the router, checks and bench

package tbxr_pkg;

   // ----------------------------------------
   // Crossbar geometry
   // ----------------------------------------
   localparam int unsigned PINS = 7;
   localparam int unsigned FIELD_W = 4;
   localparam int unsigned HALF_W = 28;
   localparam int unsigned PAT_W = 56;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned SEL_LSB = 1;
   localparam int unsigned OE_BIT = 0;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] OFF_SHIFT = 12'h000;
   localparam logic [11:0] OFF_STROBE = 12'h004;
   localparam logic [11:0] OFF_CTRL = 12'h008;
   localparam logic [11:0] OFF_ACTIVE_LO = 12'h00C;
   localparam logic [11:0] OFF_ACTIVE_HI = 12'h010;
   localparam logic [11:0] OFF_PENDING_LO = 12'h014;
   localparam logic [11:0] OFF_PENDING_HI = 12'h018;
   localparam int unsigned CTRL_P2_DRV = 0;
   localparam int unsigned CTRL_P2_RCV = 1;
   localparam int unsigned CTRL_P4_DRV = 2;
   localparam int unsigned CTRL_P4_RCV = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [55:0] PAT_RESET = 56'h00000000000000;
   localparam logic [31:0] RD_ZERO = 32'h00000000;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
   } tbxr_req_s;

   typedef struct packed {
      logic [PINS-1:0] val;
      logic [PINS-1:0] oe;
   } tbxr_side_s;

endpackage : tbxr_pkg

// >>> tbxr_switch.sv
// Purpose: Seven-by-seven crossbar switch core from an active pattern
// Assumes: Pattern comes from a register; inputs already synchronised
// Notes: Purely combinational, the top registers every B output and the A outputs for pins 0, 3, 5 and 6

`timescale 1ns/1ps

module tbxr_switch
   import tbxr_pkg::*;
(
   input wire logic [PAT_W-1:0] pattern,
   input wire logic [PINS-1:0] a_in,
   input wire logic [PINS-1:0] b_in,
   output tbxr_side_s a_out,
   output tbxr_side_s b_out
);

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   function automatic logic [SEL_W-1:0] fsel(input logic [FIELD_W-1:0] f);
      fsel = f[SEL_LSB +: SEL_W];
   endfunction : fsel

   // Selector 7 names no pin and yields a low level
   function automatic logic pick(input logic [PINS-1:0] src, input logic [SEL_W-1:0] s);
      pick = (32'(s) < PINS) ? src[s] : 1'b0;
   endfunction : pick

   genvar i;
   generate
      for (i = 0; i < PINS; i++) begin : g_pin
         logic [FIELD_W-1:0] fb;
         logic [FIELD_W-1:0] fa;
         assign fb = pattern[i*FIELD_W +: FIELD_W];
         assign fa = pattern[HALF_W + i*FIELD_W +: FIELD_W];
         assign b_out.val[i] = pick(a_in, fsel(fb));
         assign b_out.oe[i] = fb[OE_BIT];
         assign a_out.val[i] = pick(b_in, fsel(fa));
         assign a_out.oe[i] = fa[OE_BIT];
      end
   endgenerate

endmodule : tbxr_switch

// >>> tbxr_router.sv
// Purpose: Trigger bus crossbar router with APB register access
// Assumes: Single 100 MHz clock pclk, asynchronous active-low presetn
// Notes: Bidirectional pins are split into input, output and output enable

`timescale 1ns/1ps

module tbxr_router
   import tbxr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Local signals on the A side
   input wire logic external_convert_n_in,
   output logic external_convert_n_out,
   output logic external_convert_n_oe,
   input wire logic frequency_output,
   input wire logic counter2_output,
   output logic counter1_gate,
   input wire logic counter5_source_in,
   output logic counter5_source_out,
   output logic counter5_source_oe,
   input wire logic counter5_output,
   output logic timed_update_trigger_n,
   input wire logic alt_timed_update_trigger_n,
   input wire logic counter1_output_in,
   output logic counter1_output_out,
   output logic counter1_output_oe,
   input wire logic external_trigger_n_in,
   output logic external_trigger_n_out,
   output logic external_trigger_n_oe,
   // Shared trigger lines on the B side
   input wire logic [PINS-1:0] shared_trigger_line_in,
   output logic [PINS-1:0] shared_trigger_line_out,
   output logic [PINS-1:0] shared_trigger_line_oe
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int unsigned NSYNC = 15;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;

   assign raw_in = {alt_timed_update_trigger_n, shared_trigger_line_in,
                    external_trigger_n_in, counter1_output_in, counter5_output,
                    counter5_source_in, counter2_output, frequency_output,
                    external_convert_n_in};

   // Pins arrive from other boards, so two stages before any use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   logic s_conv, s_frequency_output, s_counter2_output, s_src5, s_counter5_output, s_counter1_output, s_trig, s_alt_tmr;
   logic [PINS-1:0] s_bus;
   assign s_conv = sync2_q[0];
   assign s_frequency_output = sync2_q[1];
   assign s_counter2_output = sync2_q[2];
   assign s_src5 = sync2_q[3];
   assign s_counter5_output = sync2_q[4];
   assign s_counter1_output = sync2_q[5];
   assign s_trig = sync2_q[6];
   assign s_bus = sync2_q[13:7];
   assign s_alt_tmr = sync2_q[14];
   // Only the second stage feeds logic; the first may still be settling

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   tbxr_req_s req;
   logic acc;
   logic wr_en;
   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign acc = psel & penable;
   assign wr_en = acc & req.write;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == OFF_SHIFT) || (a == OFF_STROBE) || (a == OFF_CTRL) ||
               (a == OFF_ACTIVE_LO) || (a == OFF_ACTIVE_HI) ||
               (a == OFF_PENDING_LO) || (a == OFF_PENDING_HI);
   endfunction : mapped

   // ----------------------------------------
   // Pattern shift register and count
   // ----------------------------------------
   logic [PAT_W-1:0] shift_q;
   logic [5:0] shift_cnt_q;

   // First bit written ends up at bit 0 after 56 writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_q <= PAT_RESET;
      end else if (wr_en && req.addr == OFF_SHIFT) begin
         shift_q <= {req.wdata[0], shift_q[PAT_W-1:1]};
      end
   end

   // Counts shift writes since the last strobe, saturating at 56, for software checks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_cnt_q <= 6'h00;
      end else if (wr_en && req.addr == OFF_STROBE) begin
         shift_cnt_q <= 6'h00;
      end else if (wr_en && req.addr == OFF_SHIFT && shift_cnt_q != 6'(PAT_W)) begin
         shift_cnt_q <= shift_cnt_q + 6'h01;
      end
   end

   // ----------------------------------------
   // Active pattern
   // ----------------------------------------
   logic [PAT_W-1:0] active_q;

   // Any strobe data value loads; zero is what software writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q <= PAT_RESET;
      end else if (wr_en && req.addr == OFF_STROBE) begin
         active_q <= shift_q;
      end
   end

   // ----------------------------------------
   // Shared-pin control bits
   // ----------------------------------------
   logic [3:0] ctrl_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_en && req.addr == OFF_CTRL) begin
         ctrl_q <= req.wdata[3:0];
      end
   end

   logic pin2_drive_enable, pin2_receive_enable;
   logic pin4_drive_enable, pin4_receive_enable;
   assign pin2_drive_enable = ctrl_q[CTRL_P2_DRV];
   assign pin2_receive_enable = ctrl_q[CTRL_P2_RCV];
   assign pin4_drive_enable = ctrl_q[CTRL_P4_DRV];
   assign pin4_receive_enable = ctrl_q[CTRL_P4_RCV];

   // ----------------------------------------
   // APB answer
   // ----------------------------------------
   // Zero wait states: pready is high through every access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= RD_ZERO;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped(paddr);
         prdata <= RD_ZERO;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               OFF_CTRL: prdata <= {28'h0000000, ctrl_q};
               OFF_ACTIVE_LO: prdata <= {4'h0, active_q[HALF_W-1:0]};
               OFF_ACTIVE_HI: prdata <= {4'h0, active_q[PAT_W-1:HALF_W]};
               OFF_PENDING_LO: prdata <= {4'h0, shift_q[HALF_W-1:0]};
               OFF_PENDING_HI: prdata <= {shift_cnt_q[3:0], shift_q[PAT_W-1:HALF_W]};
               default: prdata <= RD_ZERO;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Crossbar core
   // ----------------------------------------
   logic [PINS-1:0] a_drive;
   logic [PINS-1:0] a_level;
   tbxr_side_s a_sw;
   tbxr_side_s b_sw;

   // Level seen on each A pin: switch output when enabled, else local source
   always_comb begin
      a_drive = {s_trig, s_counter1_output, s_counter5_output, s_src5, s_counter2_output, s_frequency_output, s_conv};
      for (int k = 0; k < PINS; k++) begin
         a_level[k] = a_sw.oe[k] ? a_sw.val[k] : a_drive[k];
      end
      // Shared pins only carry the counter output when its drive bit is set
      if (!a_sw.oe[2]) begin
         a_level[2] = pin2_drive_enable & s_counter2_output;
      end
      if (!a_sw.oe[4]) begin
         a_level[4] = pin4_drive_enable & s_counter5_output;
      end
   end

   tbxr_switch u_switch (
      .pattern(active_q),
      .a_in(a_level),
      .b_in(s_bus),
      .a_out(a_sw),
      .b_out(b_sw)
   );

   // ----------------------------------------
   // Registered pin outputs
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_trigger_line_out <= '0;
         shared_trigger_line_oe <= '0;
      end else begin
         shared_trigger_line_out <= b_sw.val;
         shared_trigger_line_oe <= b_sw.oe;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         external_convert_n_out <= 1'b0;
         external_convert_n_oe <= 1'b0;
         counter5_source_out <= 1'b0;
         counter5_source_oe <= 1'b0;
         counter1_output_out <= 1'b0;
         counter1_output_oe <= 1'b0;
         external_trigger_n_out <= 1'b0;
         external_trigger_n_oe <= 1'b0;
      end else begin
         external_convert_n_out <= a_sw.val[0];
         external_convert_n_oe <= a_sw.oe[0];
         counter5_source_out <= a_sw.val[3];
         counter5_source_oe <= a_sw.oe[3];
         counter1_output_out <= a_sw.val[5];
         counter1_output_oe <= a_sw.oe[5];
         external_trigger_n_out <= a_sw.val[6];
         external_trigger_n_oe <= a_sw.oe[6];
      end
   end

   // Receive paths; gate idles low, trigger follows alt_timed_update_trigger_n when not selected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter1_gate <= 1'b0;
         timed_update_trigger_n <= 1'b1;
      end else begin
         counter1_gate <= pin2_receive_enable & a_level[2];
         timed_update_trigger_n <= pin4_receive_enable ? a_level[4] : s_alt_tmr;
      end
   end

endmodule : tbxr_router

// >>> tbxr_router_asserts.sv
// Purpose: Port-level checks for the trigger bus crossbar router
// Assumes: One clock pclk, asynchronous reset presetn
// Notes: Mirrors the control word from APB writes, as it is not a port
`timescale 1ns/1ps
module tbxr_router_asserts
   import tbxr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic counter2_output,
   input wire logic counter1_gate,
   input wire logic counter5_output,
   input wire logic timed_update_trigger_n,
   input wire logic alt_timed_update_trigger_n,
   input wire logic [PINS-1:0] shared_trigger_line_oe
);
   // ----------------------------------------
   // Helper state
   // ----------------------------------------
   logic [3:0] ctrl_q;
   logic [2:0] strb_q;
   logic wr_ok;
   assign wr_ok = psel && penable && pready && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_q <= 4'h0;
      else if (wr_ok && paddr == OFF_CTRL) ctrl_q <= pwdata[3:0];
   end
   // Three deep, so a registered switch output still finds its strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) strb_q <= 3'h0;
      else strb_q <= {strb_q[1:0], wr_ok && paddr == OFF_STROBE};
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence
   a_zero_wait: assert property (setup_s |=> access_s)
      else $error("pready late");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("stray pready");
   a_unmapped_err: assert property (access_s |-> pslverr ==
      !((paddr[1:0] == 2'h0) && (paddr <= OFF_PENDING_HI))) else $error("pslverr wrong");
   a_idle_rdata: assert property (!pready |-> prdata == RD_ZERO)
      else $error("prdata idle");
   a_reset_quiet: assert property ($rose(presetn) |-> shared_trigger_line_oe == 7'h00
      && timed_update_trigger_n && !counter1_gate) else $error("driven after reset");
   a_strobe_only: assert property ($changed(shared_trigger_line_oe) |-> strb_q != 3'h0)
      else $error("routing changed without strobe");
   a_gate_block: assert property ((!ctrl_q[CTRL_P2_RCV])[*4] |-> !counter1_gate)
      else $error("gate not blocked");
   a_gate_loop: assert property ((ctrl_q[CTRL_P2_RCV] && ctrl_q[CTRL_P2_DRV])[*5]
      |-> counter1_gate == $past(counter2_output, 3)) else $error("gate loop wrong");
   a_trig_alt: assert property ((!ctrl_q[CTRL_P4_RCV])[*5]
      |-> timed_update_trigger_n == $past(alt_timed_update_trigger_n, 3)) else $error("alt");
   a_trig_loop: assert property ((ctrl_q[CTRL_P4_RCV] && ctrl_q[CTRL_P4_DRV])[*5]
      |-> timed_update_trigger_n == $past(counter5_output, 3)) else $error("trig loop");
endmodule : tbxr_router_asserts

// >>> tbxr_trig_peer.sv
// Purpose: Other boards on the shared trigger lines
// Assumes: Peers drive every line the router releases
// Notes: No pull-ups, so a released line always has an owner
`timescale 1ns/1ps
module tbxr_trig_peer
   import tbxr_pkg::*;
(
   input wire logic [PINS-1:0] peer_val,
   input wire tbxr_side_s dut_b,
   output logic [PINS-1:0] line
);
   // ----------------------------------------
   // Line resolution
   // ----------------------------------------
   assign line = (dut_b.oe & dut_b.val) | (~dut_b.oe & peer_val);
endmodule : tbxr_trig_peer

// >>> tb_top.sv
// Purpose: Self-checking bench for the crossbar router
// Assumes: Zero-wait APB slave, three-edge pin latency
// Notes: A-pin levels resolve from the router enables
`timescale 1ns/1ps
module tb_top
   import tbxr_pkg::*;
;
   // ----------------------------------------
   // Signals and helpers
   // ----------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000EC93;
   logic pready, pslverr, counter1_gate, timed_update_trigger_n;
   logic external_convert_n_out, external_convert_n_oe, counter5_source_out, counter5_source_oe;
   logic counter1_output_out, counter1_output_oe, external_trigger_n_out, external_trigger_n_oe;
   logic [PINS-1:0] shared_trigger_line_out, shared_trigger_line_oe, peer = 7'h00;
   wire [PINS-1:0] shared_trigger_line_in;
   logic [7:0] lv = 8'h00;
   logic [32:0] exp_q[$];
   int mismatches = 0, tests_run = 0;
   wire external_convert_n_in = external_convert_n_oe ? external_convert_n_out : lv[0];
   wire frequency_output = lv[1];
   wire counter2_output = lv[2];
   wire counter5_source_in = counter5_source_oe ? counter5_source_out : lv[3];
   wire counter5_output = lv[4];
   wire counter1_output_in = counter1_output_oe ? counter1_output_out : lv[5];
   wire external_trigger_n_in = external_trigger_n_oe ? external_trigger_n_out : lv[6];
   wire alt_timed_update_trigger_n = lv[7];
   wire tbxr_side_s b_side = {shared_trigger_line_out, shared_trigger_line_oe};
   tbxr_router DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_convert_n_in(external_convert_n_in),
      .external_convert_n_out(external_convert_n_out),
      .external_convert_n_oe(external_convert_n_oe), .frequency_output(frequency_output),
      .counter2_output(counter2_output), .counter1_gate(counter1_gate),
      .counter5_source_in(counter5_source_in), .counter5_source_out(counter5_source_out),
      .counter5_source_oe(counter5_source_oe), .counter5_output(counter5_output),
      .timed_update_trigger_n(timed_update_trigger_n),
      .alt_timed_update_trigger_n(alt_timed_update_trigger_n),
      .counter1_output_in(counter1_output_in), .counter1_output_out(counter1_output_out),
      .counter1_output_oe(counter1_output_oe), .external_trigger_n_in(external_trigger_n_in),
      .external_trigger_n_out(external_trigger_n_out),
      .external_trigger_n_oe(external_trigger_n_oe),
      .shared_trigger_line_in(shared_trigger_line_in),
      .shared_trigger_line_out(shared_trigger_line_out),
      .shared_trigger_line_oe(shared_trigger_line_oe)
   );
   tbxr_trig_peer u_peer (.peer_val(peer), .dut_b(b_side), .line(shared_trigger_line_in));
   always #5 pclk = ~pclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      if (!w) exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      // No wait count assumed; only the watchdog ends a stall
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         check({pslverr, prdata}, exp_q.pop_front());
      end
   end
   // Upper data bits are random so a leak into the pattern shows
   task automatic load(input logic [55:0] p, input logic [55:0] old);
      logic [31:0] r;
      for (int i = 0; i < 56; i++) begin
         r = rnd();
         r[0] = p[i];
         apb(OFF_SHIFT, 1'b1, r, 33'h0);
      end
      apb(OFF_PENDING_LO, 1'b0, 32'h0, {5'h0, p[27:0]});
      apb(OFF_PENDING_HI, 1'b0, 32'h0, {5'h08, p[55:28]});
      apb(OFF_ACTIVE_LO, 1'b0, 32'h0, {5'h0, old[27:0]});
      apb(OFF_STROBE, 1'b1, 32'h0, 33'h0);
      apb(OFF_ACTIVE_HI, 1'b0, 32'h0, {5'h0, p[55:28]});
   endtask : load
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      logic [55:0] pat, old;
      logic [2:0] sv;
      logic [3:0] cv;
      repeat (5) @(posedge pclk);
      check({shared_trigger_line_oe, external_trigger_n_oe, timed_update_trigger_n,
         counter1_gate}, 10'h002);
      presetn <= 1'b1;
      apb(OFF_CTRL, 1'b0, 32'h0, {29'h0, CTRL_RESET});
      apb(12'h01C, 1'b0, 32'h0, {1'b1, RD_ZERO});
      apb(OFF_ACTIVE_LO, 1'b1, 32'hFFFFFFFF, 33'h0);
      apb(OFF_CTRL, 1'b1, 32'h5, 33'h0);
      old = PAT_RESET;
      for (int s = 0; s < 8; s++) begin
         sv = s[2:0];
         r = rnd();
         lv <= r[7:0];
         peer <= r[14:8];
         pat = {sv, 1'b1, 48'h0, sv, 1'b1};
         load(pat, old);
         old = pat;
         repeat (3) @(posedge pclk);
         check({shared_trigger_line_out[0], external_trigger_n_out},
            {(sv == 3'h6) ? peer[6] : ((sv == 3'h7) ? 1'b0 : lv[sv]),
            (sv == 3'h0) ? lv[0] : ((sv == 3'h7) ? 1'b0 : peer[sv])});
         check({shared_trigger_line_oe, external_convert_n_oe, counter5_source_oe,
            counter1_output_oe, external_trigger_n_oe}, 11'h011);
      end
      // A0, A3 and A5 take B3 and B4 takes A5, so the A0, A3 and A5 outputs are seen
      r = rnd();
      peer <= r[6:0];
      pat = 56'h070700700B0000;
      load(pat, old);
      old = pat;
      repeat (3) @(posedge pclk);
      check({external_convert_n_out, counter5_source_out, counter1_output_out,
         shared_trigger_line_out[4]}, {4{peer[3]}});
      check({shared_trigger_line_oe, external_convert_n_oe, counter5_source_oe,
         counter1_output_oe, external_trigger_n_oe}, 11'h10E);
      for (int c = 0; c < 16; c++) begin
         cv = c[3:0];
         r = rnd();
         apb(OFF_CTRL, 1'b1, {r[31:4], cv}, 33'h0);
         apb(OFF_CTRL, 1'b0, 32'h0, {29'h0, cv});
         lv <= r[11:4];
         repeat (4) @(posedge pclk);
         check({counter1_gate, timed_update_trigger_n},
            {cv[1] & cv[0] & lv[2], cv[3] ? cv[2] & lv[4] : lv[7]});
      end
      presetn <= 1'b0;
      @(posedge pclk);
      check({shared_trigger_line_oe, external_trigger_n_oe, timed_update_trigger_n,
         counter1_gate}, 10'h002);
      presetn <= 1'b1;
      apb(OFF_ACTIVE_HI, 1'b0, 32'h0, 33'h0);
      wrap_up();
   end
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
endmodule : tb_top
bind tbxr_router tbxr_router_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .counter2_output(counter2_output),
   .counter1_gate(counter1_gate), .counter5_output(counter5_output),
   .timed_update_trigger_n(timed_update_trigger_n),
   .alt_timed_update_trigger_n(alt_timed_update_trigger_n),
   .shared_trigger_line_oe(shared_trigger_line_oe));
